// *** design/supervisor_watchdog_reset.sv ***
// What this block does
// RL1 - Stuck data line past timeout asserts reset
// RL2 - Start then stop restarts the watchdog
// RL3 - Settings: 200 ms, 600 ms, 1.4 s, off
// RL4 - Period setting survives supply loss
// RL5 - Write-protect high blocks period changes
// RL6 - Low supply asserts reset
// RL7 - Release 250 ms after supply stays good
// RL8 - Power-up holds reset 250 ms
// RL9 - Power-on release needs 200 ms good supply
// RL10 - Open-drain reset, polarity per variant
// RL11 - Data line watched always, never gated
// RL12 - Code 00/01/10/11 = 1.4s/600ms/200ms/off
// RL13 - Delays from time base; reset clears watchdog
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module supervisor_watchdog_reset
  import sup_wdt_pkg::*;
#(
  parameter int TICK_CYC          = TICK_CYCLES,
  parameter bit RESET_ACTIVE_HIGH = 1'b0
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        nv_init_n_i,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sda_i,
  input  wire logic        scl_i,
  input  wire logic        wp_i,
  input  wire logic        supply_ok_i,
  output logic             rst_out_o,
  output logic             rst_out_oe_o
);

  localparam int PW = $clog2(TICK_CYC + 1);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Order: {supply_ok, wp, scl, sda}
  logic [3:0] pin_meta_ff;
  logic [3:0] pin_sync_ff;
  logic [3:0] pin_raw;
  logic       sda_s;
  logic       scl_s;
  logic       wp_s;
  logic       supply_s;

  // Data line is sampled unconditionally, whatever the bus is doing
  assign pin_raw = {supply_ok_i, wp_i, scl_i, sda_i};  // see RL11

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_meta_ff <= 4'h0;
      pin_sync_ff <= 4'h0;
    end else begin
      pin_meta_ff <= pin_raw;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  assign sda_s    = pin_sync_ff[0];
  assign scl_s    = pin_sync_ff[1];
  assign wp_s     = pin_sync_ff[2];
  assign supply_s = pin_sync_ff[3];

  // ----------------------------------------
  // Time base
  // ----------------------------------------
  logic [PW-1:0] pre_ff;
  logic [PW-1:0] nxt_pre;
  logic          tick;

  assign tick = (pre_ff == PW'(TICK_CYC - 1));

  always_comb begin
    nxt_pre = tick ? '0 : pre_ff + PW'(1);  // see RL13
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_ff <= '0;
    end else begin
      pre_ff <= nxt_pre;
    end
  end

  // ----------------------------------------
  // Nonvolatile period setting
  // ----------------------------------------
  // Reset only by the factory-init input, never by power-on reset,
  // so the setting outlives a supply cycle.
  logic [1:0] period_ff;
  logic [1:0] nxt_period;
  logic       apb_wr;
  logic       apb_rd_setup;
  logic       hit_ctrl;
  logic       hit_status;

  assign hit_ctrl     = (paddr == CTRL_OFF);
  assign hit_status   = (paddr == STATUS_OFF);
  assign apb_wr       = psel && penable && pwrite;
  assign apb_rd_setup = psel && !penable && !pwrite;

  always_comb begin
    nxt_period = period_ff;
    if (apb_wr && hit_ctrl && !wp_s) begin  // see RL5
      nxt_period = pwdata[CTRL_PER_LSB +: 2];
    end
  end

  always_ff @(posedge clk_i or negedge nv_init_n_i) begin
    if (!nv_init_n_i) begin
      period_ff <= PERIOD_RESET;  // see RL4
    end else begin
      period_ff <= nxt_period;  // see RL4
    end
  end

  // ----------------------------------------
  // Watchdog restart detection
  // ----------------------------------------
  logic sda_q_ff;
  logic scl_q_ff;
  logic armed_ff;
  logic nxt_armed;
  logic start_seen;
  logic stop_seen;
  logic wdt_restart;

  // Start: data falls with clock high; stop: data rises with clock high
  assign start_seen = scl_s && scl_q_ff && sda_q_ff && !sda_s;
  assign stop_seen  = scl_s && scl_q_ff && !sda_q_ff && sda_s;
  assign wdt_restart = armed_ff && stop_seen;  // see RL2

  always_comb begin
    nxt_armed = armed_ff;
    if (start_seen) begin
      nxt_armed = 1'b1;  // see RL2
    end else if (stop_seen) begin
      nxt_armed = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sda_q_ff <= 1'b1;
      scl_q_ff <= 1'b1;
      armed_ff <= 1'b0;
    end else begin
      sda_q_ff <= sda_s;
      scl_q_ff <= scl_s;
      armed_ff <= nxt_armed;
    end
  end

  // ----------------------------------------
  // Watchdog period decode
  // ----------------------------------------
  logic [CNT_W-1:0] wdt_limit;
  logic             wdt_on;

  always_comb begin
    wdt_on = 1'b1;
    case (period_ff)  // see RL12
      WDT_CODE_LONG:  wdt_limit = WDT_LONG_TICKS;  // see RL3
      WDT_CODE_MID:   wdt_limit = WDT_MID_TICKS;  // see RL3
      WDT_CODE_SHORT: wdt_limit = WDT_SHORT_TICKS;  // see RL3
      default: begin
        wdt_limit = WDT_LONG_TICKS;
        wdt_on    = 1'b0;  // see RL3
      end
    endcase
  end

  // ----------------------------------------
  // Supervisor state machine
  // ----------------------------------------
  sup_state_t state_ff;
  sup_state_t nxt_state;
  logic       rel_done;
  logic       rel_clr;
  logic       wdt_done;
  logic       wdt_clr;
  logic       period_chg;
  logic       reset_act;

  assign period_chg = (nxt_period != period_ff);
  assign reset_act  = (state_ff != SUP_RUN);

  // Release delay counts only while the supply stays good; a dip restarts it
  assign rel_clr = !supply_s || (nxt_state != state_ff) || (state_ff == SUP_RUN);  // see RL7

  // Held clear while reset is out, while off, and on each restart
  assign wdt_clr = reset_act || !wdt_on || wdt_restart || period_chg;  // see RL13

  delay_timer #(
    .W (CNT_W)
  ) u_release (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .tick_i  (tick),
    .clr_i   (rel_clr),
    .limit_i (RELEASE_TICKS),
    .done_o  (rel_done)
  );

  delay_timer #(
    .W (CNT_W)
  ) u_watchdog (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .tick_i  (tick),
    .clr_i   (wdt_clr),
    .limit_i (wdt_limit),
    .done_o  (wdt_done)
  );

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SUP_POR: begin
        // 250 ms of good supply also covers the 200 ms nominal
        if (rel_done) begin
          nxt_state = SUP_RUN;  // see RL8, RL9
        end
      end
      SUP_RUN: begin
        if (!supply_s) begin
          nxt_state = SUP_LOWV;  // see RL6
        end else if (wdt_on && wdt_done) begin
          nxt_state = SUP_WDT;  // see RL1
        end
      end
      SUP_LOWV: begin
        if (rel_done) begin
          nxt_state = SUP_RUN;  // see RL7
        end
      end
      SUP_WDT: begin
        if (!supply_s) begin
          nxt_state = SUP_LOWV;  // see RL6
        end else if (rel_done) begin
          nxt_state = SUP_RUN;
        end
      end
      default: begin
        nxt_state = SUP_POR;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= SUP_POR;  // see RL8
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------
  // Open-drain reset pin
  // ----------------------------------------
  // Active-low variant pulls low while active; active-high variant
  // pulls low while inactive and lets the pull-up assert.
  logic rst_oe_ff;
  logic nxt_rst_oe;

  always_comb begin
    if (RESET_ACTIVE_HIGH) begin
      nxt_rst_oe = !(nxt_state != SUP_RUN);  // see RL10
    end else begin
      nxt_rst_oe = (nxt_state != SUP_RUN);  // see RL10
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_oe_ff <= !RESET_ACTIVE_HIGH;  // see RL8
    end else begin
      rst_oe_ff <= nxt_rst_oe;
    end
  end

  assign rst_out_o    = 1'b0;
  assign rst_out_oe_o = rst_oe_ff;

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // Zero wait states; read data is captured in the setup cycle so
  // it comes from a flop yet is ready in the access cycle.
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [31:0] status_word;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_RST_BIT]    = reset_act;
    status_word[ST_POR_BIT]    = (state_ff == SUP_POR);
    status_word[ST_LOWV_BIT]   = (state_ff == SUP_LOWV);
    status_word[ST_WDT_BIT]    = (state_ff == SUP_WDT);
    status_word[ST_SUPPLY_BIT] = supply_s;
    status_word[ST_WP_BIT]     = wp_s;
    status_word[ST_SDA_BIT]    = sda_s;
  end

  always_comb begin
    nxt_rdata = rdata_ff;
    if (apb_rd_setup) begin
      nxt_rdata = 32'h0000_0000;
      if (hit_ctrl) begin
        nxt_rdata[CTRL_PER_LSB +: 2] = period_ff;
      end else if (hit_status) begin
        nxt_rdata = status_word;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign prdata  = rdata_ff;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !(hit_ctrl || hit_status);

endmodule

`default_nettype wire

// *** design/sup_wdt_pkg.sv ***
package sup_wdt_pkg;

  // ----------------------------------------
  // Time base
  // ----------------------------------------
  localparam int CLK_PERIOD_NS  = 8;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int NS_PER_MS      = 1000000;

  // ----------------------------------------
  // Delays, in the units printed
  // ----------------------------------------
  localparam int WDT_SHORT_MS   = 200;
  localparam int WDT_MID_MS     = 600;
  localparam int WDT_LONG_MS    = 1400;
  localparam int RELEASE_MS     = 250;
  localparam int POR_NOMINAL_MS = 200;

  // Counts of time-base ticks; longest is 1400, so 11 bits suffice
  localparam int CNT_W = 11;
  localparam logic [CNT_W-1:0] WDT_SHORT_TICKS =
    CNT_W'(WDT_SHORT_MS * (NS_PER_MS / TICK_PERIOD_NS));
  localparam logic [CNT_W-1:0] WDT_MID_TICKS =
    CNT_W'(WDT_MID_MS * (NS_PER_MS / TICK_PERIOD_NS));
  localparam logic [CNT_W-1:0] WDT_LONG_TICKS =
    CNT_W'(WDT_LONG_MS * (NS_PER_MS / TICK_PERIOD_NS));
  localparam logic [CNT_W-1:0] RELEASE_TICKS =
    CNT_W'(RELEASE_MS * (NS_PER_MS / TICK_PERIOD_NS));

  // ----------------------------------------
  // Watchdog period codes {wdt_period_hi, wdt_period_lo}
  // ----------------------------------------
  localparam logic [1:0] WDT_CODE_LONG  = 2'h0;
  localparam logic [1:0] WDT_CODE_MID   = 2'h1;
  localparam logic [1:0] WDT_CODE_SHORT = 2'h2;
  localparam logic [1:0] WDT_CODE_OFF   = 2'h3;
  localparam logic [1:0] PERIOD_RESET   = WDT_CODE_OFF;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam int CTRL_PER_LSB   = 0;
  localparam int ST_RST_BIT     = 0;
  localparam int ST_POR_BIT     = 1;
  localparam int ST_LOWV_BIT    = 2;
  localparam int ST_WDT_BIT     = 3;
  localparam int ST_SUPPLY_BIT  = 4;
  localparam int ST_WP_BIT      = 5;
  localparam int ST_SDA_BIT     = 6;

  // ----------------------------------------
  // Supervisor states
  // ----------------------------------------
  typedef enum logic [3:0] {
    SUP_POR  = 4'h1,
    SUP_RUN  = 4'h2,
    SUP_LOWV = 4'h4,
    SUP_WDT  = 4'h8
  } sup_state_t;

endpackage

// *** design/delay_timer.sv ***
`timescale 1ns/100ps
`default_nettype none

module delay_timer
  import sup_wdt_pkg::*;
#(
  parameter int W = CNT_W
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         tick_i,
  input  wire logic         clr_i,
  input  wire logic [W-1:0] limit_i,
  output logic              done_o
);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  // ----------------------------------------
  // Tick counter, saturating at the limit
  // ----------------------------------------
  always_comb begin
    nxt_cnt = cnt_ff;
    if (clr_i) begin
      nxt_cnt = '0;
    end else if (tick_i && !done_o) begin
      nxt_cnt = cnt_ff + W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign done_o = (cnt_ff >= limit_i);

endmodule

`default_nettype wire

// *** dv/sup_wdt_chk_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module sup_wdt_chk
  import sup_wdt_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES,
  parameter bit RAH      = 1'b0
) (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sda_i,
  input wire logic        supply_ok_i,
  input wire logic        rst_out_o,
  input wire logic        rst_out_oe_o
);
  // ---
  // Spans in clocks; 32 bits cannot wrap within a run
  // ---
  localparam int REL_MIN = (int'(RELEASE_TICKS) - 1) * TICK_CYC;
  localparam int WDT_MIN = (int'(WDT_SHORT_TICKS) - 1) * TICK_CYC;
  logic        act, acc, sda_ff;
  logic [31:0] good_ff, still_ff, nxt_good, nxt_still;
  assign act = rst_out_oe_o ^ RAH;
  assign acc = psel && penable;
  always_comb begin
    nxt_good  = supply_ok_i ? good_ff + 32'h0000_0001 : 32'h0000_0000;
    nxt_still = (sda_i != sda_ff) ? 32'h0000_0000 : still_ff + 32'h0000_0001;
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      good_ff  <= 32'h0000_0000;
      still_ff <= 32'h0000_0000;
      sda_ff   <= 1'b1;
    end else begin
      good_ff  <= nxt_good;
      still_ff <= nxt_still;
      sda_ff   <= sda_i;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_od; rst_out_o == 1'b0; endproperty
  a_od: assert property (p_od) else $error("reset pin data not low");
  property p_lowv; $fell(supply_ok_i) |-> ##[1:6] act; endproperty
  a_lowv: assert property (p_lowv) else $error("low supply missed");
  property p_hold; (!supply_ok_i) [*6] |-> act; endproperty
  a_hold: assert property (p_hold) else $error("reset off in low supply");
  property p_rel; $fell(act) |-> good_ff >= REL_MIN; endproperty
  a_rel: assert property (p_rel) else $error("release too early");
  property p_trip; $rose(act) && good_ff > 32'h0000_0010 |-> still_ff >= WDT_MIN; endproperty
  a_trip: assert property (p_trip) else $error("trip before timeout");
  property p_por; $rose(rst_n_i) |-> act [*8]; endproperty
  a_por: assert property (p_por) else $error("power-on hold lost");
  property p_rdy; acc |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready in access");
  property p_unm; acc && paddr != CTRL_OFF && paddr != STATUS_OFF |-> pslverr && prdata == '0;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped access not refused");
  c_trip: cover property ($rose(act) && good_ff > 32'h0000_0010);
  c_rel: cover property ($fell(act));
  c_err: cover property (acc && pslverr);
endmodule
bind supervisor_watchdog_reset sup_wdt_chk #(.TICK_CYC(TICK_CYC), .RAH(RESET_ACTIVE_HIGH)) u_chk (
  .clk_i, .rst_n_i, .psel, .penable, .paddr, .prdata, .pready, .pslverr,
  .sda_i, .supply_ok_i, .rst_out_o, .rst_out_oe_o
);
`default_nettype wire

// *** dv/host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module host_model (
  output var logic sda_o,
  output var logic scl_o
);
  // Lines rest at the pull-up level; clock stands still between frames
  initial begin
    sda_o = 1'b1;
    scl_o = 1'b1;
  end
  task automatic frame(input logic b);
    #3 sda_o = 1'b0;
    #40 scl_o = 1'b0;
    #20 sda_o = b;
    #20 scl_o = 1'b1;
    #40 scl_o = 1'b0;
    #20 sda_o = 1'b0;
    #20 scl_o = 1'b1;
    #40 sda_o = 1'b1;
  endtask
endmodule
`default_nettype wire

// *** dv/supervisor_watchdog_reset_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module supervisor_watchdog_reset_bench;
  import sup_wdt_pkg::*;
  localparam int TC  = 10;
  localparam int REL = int'(RELEASE_TICKS) * TC;
  logic        clk_i, rst_n_i, nv_init_n_i, psel, penable, pwrite, pready, pslverr;
  logic        sda, scl, wp_i, supply_ok_i, rst_out_o, rst_out_oe_o, oe_hi;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic [32:0] expq[$];
  logic [1:0]  codes[3] = '{WDT_CODE_SHORT, WDT_CODE_MID, WDT_CODE_LONG};
  int          tks[3] = '{int'(WDT_SHORT_TICKS), int'(WDT_MID_TICKS), int'(WDT_LONG_TICKS)};
  int          err_total, checks, cyc, n;
  supervisor_watchdog_reset #(.TICK_CYC(TC)) dut (
    .clk_i, .rst_n_i, .nv_init_n_i, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sda_i(sda), .scl_i(scl), .wp_i, .supply_ok_i,
    .rst_out_o, .rst_out_oe_o
  );
  // Active-high variant on the same inputs; its enable must mirror the first one
  supervisor_watchdog_reset #(.TICK_CYC(TC), .RESET_ACTIVE_HIGH(1'b1)) dut_hi (
    .clk_i, .rst_n_i, .nv_init_n_i, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata(), .pready(), .pslverr(), .sda_i(sda), .scl_i(scl), .wp_i, .supply_ok_i,
    .rst_out_o(), .rst_out_oe_o(oe_hi)
  );
  host_model u_host (.sda_o(sda), .scl_o(scl));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_rng(input int v, input int lo, input int hi);
    chk((v >= lo && v <= hi) ? 33'(lo) : 33'(v), 33'(lo));
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    expq.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic ticks(input int k);
    repeat (k * TC) @(posedge clk_i);
  endtask
  // Counts clocks until the reset output enable reaches v, bounded
  task automatic wait_oe(input logic v);
    n = 0;
    while (rst_out_oe_o !== v && n < 20000) begin
      @(posedge clk_i);
      n++;
    end
    chk(33'(oe_hi), 33'(!v));
  endtask
  task automatic print_verdict;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    if (psel && penable && pready && !pwrite) begin
      chk({pslverr, prdata}, expq.pop_front());
    end
    cyc++;
    if (cyc == 70000) begin
      err_total++;
      print_verdict();
    end
  end
  initial begin
    {rst_n_i, nv_init_n_i, psel, penable, pwrite, wp_i} = 6'h00;
    {paddr, pwdata} = '0;
    supply_ok_i = 1'b1;
    rnd = 32'h0000_0053;
    {err_total, checks, cyc} = '0;
    repeat (16) @(posedge clk_i);
    rst_n_i     <= 1'b1;
    nv_init_n_i <= 1'b1;
    wait_oe(1'b0);
    chk_rng(n, REL - TC - 8, REL + 8);
    rd(CTRL_OFF, {31'h0, PERIOD_RESET});
    rd(8'h08, 33'h1_0000_0000);
    wp_i <= 1'b1;
    ticks(1);
    apb(1'b1, CTRL_OFF, 32'h0000_0002);
    rd(CTRL_OFF, {31'h0, WDT_CODE_OFF});
    wp_i <= 1'b0;
    ticks(1);
    for (int i = 0; i < 3; i++) begin
      rnd = xs(rnd);
      apb(1'b1, CTRL_OFF, {rnd[31:2], codes[i]});
      rd(CTRL_OFF, {31'h0, codes[i]});
      u_host.frame(rnd[0]);
      wait_oe(1'b1);
      chk_rng(n, (tks[i] - 1) * TC - 8, tks[i] * TC + 8);
      wait_oe(1'b0);
      chk_rng(n, REL - TC - 8, REL + 8);
    end
    apb(1'b1, CTRL_OFF, {30'h0, WDT_CODE_SHORT});
    repeat (5) begin
      rnd = xs(rnd);
      ticks(100 + int'(rnd[5:0]));
      u_host.frame(rnd[1]);
    end
    chk({32'h0, rst_out_oe_o}, 33'h0);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    ticks(1);
    rst_n_i <= 1'b1;
    wait_oe(1'b0);
    chk_rng(n, REL - TC - 8, REL + 8);
    rd(CTRL_OFF, {31'h0, WDT_CODE_SHORT});
    apb(1'b1, CTRL_OFF, {30'h0, WDT_CODE_OFF});
    ticks(300);
    chk({32'h0, rst_out_oe_o}, 33'h0);
    supply_ok_i <= 1'b0;
    wait_oe(1'b1);
    chk_rng(n, 1, 6);
    supply_ok_i <= 1'b1;
    ticks(100);
    supply_ok_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    supply_ok_i <= 1'b1;
    wait_oe(1'b0);
    chk_rng(n, REL - TC - 8, REL + 8);
    print_verdict();
  end
endmodule
`default_nettype wire
